//--- hdl/txsa_pkg.sv
package txsa_pkg;

  // ***********************************************
  // Register map and field positions
  // ***********************************************
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] CFG_ADDR = 4'h1;
  localparam int FORCE_BUSY_BIT = 12;
  localparam int ACCESSED_BIT = 11;
  localparam int NEXT_BUF_BIT = 10;
  localparam int ACK_BIT = 8;
  localparam int ENABLE_BIT = 2;
  localparam int GLOBAL_BUSY_BIT = 0;
  localparam int FREEZE_BIT = 1;
  localparam int BUF_MODE_LSB = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ***********************************************
  // Buffer modes
  // ***********************************************
  typedef enum logic [1:0] {
    MODE_PINGPONG = 2'h0,
    MODE_INDEXED = 2'h1,
    MODE_CIRC1 = 2'h2,
    MODE_CIRC2 = 2'h3
  } buf_mode_t;

  // Message end report from the protocol engine
  typedef struct packed {
    logic done;
    logic error;
    logic illegal;
  } msg_end_t;

  // Command start report
  typedef struct packed {
    logic valid;
  } msg_start_t;

  // ***********************************************
  // Message tracking states
  // ***********************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MSG = 2'b10
  } msg_state_t;

endpackage

//--- hdl/rt_tx_subaddr_ctrl_bits.sv
`timescale 1ns/100ps
// Behaviour
// (R01) Force-busy flag makes status Busy bit set
// (R02) Busy message: no data, pointer kept
// (R03) Per-subaddress busy independent of global busy
// (R04) Set accessed flag at message completion
// (R05) Clear accessed on reset, soft reset, read
// (R06) Host may poll accessed flag for activity
// (R07) Pointer picks buffer A or B, read-only
// (R08) Toggle pointer after each error-free message
// (R09) Host should set freeze to protect pointer
// (R10) Resets clear pointer to buffer A
// (R11) Pointer ignored in indexed or circular modes
// (R12) Ping-pong without ack: keep pointer steady
// (R13) Force-busy flag changes only by host write
module rt_tx_subaddr_ctrl_bits
  import txsa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic soft_reset_cmd,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Protocol engine side
  input wire txsa_pkg::msg_start_t msg_start,
  input wire txsa_pkg::msg_end_t msg_end,
  input wire logic pingpong_ack_flag,
  output logic busy_status,
  output logic send_data,
  output logic use_buffer_b
);
  import txsa_pkg::*;

  // ***********************************************
  // Control and configuration state
  // ***********************************************
  logic force_busy_flag_q, force_busy_flag_d;
  logic descriptor_accessed_flag_q, descriptor_accessed_flag_d;
  logic next_buffer_select_q, next_buffer_select_d;
  logic pingpong_enable_flag_q, pingpong_enable_flag_d;
  logic global_busy_q, global_busy_d;
  logic freeze_pointer_on_fail_q, freeze_pointer_on_fail_d;
  buf_mode_t buf_mode_q, buf_mode_d;
  msg_state_t state_q, state_d;
  logic msg_busy_q, msg_busy_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] ctrl_word;
  logic pp_active;
  logic busy_now;
  logic clr;
  logic wr_ctrl;
  logic wr_cfg;
  logic rd_ctrl;
  logic rd_cfg;
  logic msg_done;
  logic ptr_advance;

  assign clr = soft_reset_cmd;
  assign pp_active = pingpong_enable_flag_q && pingpong_ack_flag
    && (buf_mode_q == MODE_PINGPONG); // [R11] [R12]
  assign busy_now = force_busy_flag_q || global_busy_q; // [R03]

  always_comb begin
    ctrl_word = CTRL_RESET;
    ctrl_word[FORCE_BUSY_BIT] = force_busy_flag_q;
    ctrl_word[ACCESSED_BIT] = descriptor_accessed_flag_q;
    ctrl_word[NEXT_BUF_BIT] = next_buffer_select_q;
    ctrl_word[ACK_BIT] = pingpong_ack_flag;
    ctrl_word[ENABLE_BIT] = pingpong_enable_flag_q;
  end

  // ***********************************************
  // Access decode
  // ***********************************************
  assign wr_ctrl = wr && (addr == CTRL_ADDR);
  assign wr_cfg = wr && (addr == CFG_ADDR);
  assign rd_ctrl = rd && (addr == CTRL_ADDR);
  assign rd_cfg = rd && (addr == CFG_ADDR);
  assign msg_done = (state_q == ST_MSG) && msg_end.done;

  // ***********************************************
  // Host-owned control bits
  // ***********************************************
  always_comb begin
    force_busy_flag_d = force_busy_flag_q;
    pingpong_enable_flag_d = pingpong_enable_flag_q;
    // Only a host write moves the busy flag
    if (wr_ctrl) begin
      force_busy_flag_d = wdata[FORCE_BUSY_BIT]; // [R13]
      pingpong_enable_flag_d = wdata[ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      force_busy_flag_q <= 1'b0;
      pingpong_enable_flag_q <= 1'b0;
    end else begin
      force_busy_flag_q <= force_busy_flag_d;
      pingpong_enable_flag_q <= pingpong_enable_flag_d;
    end
  end

  // ***********************************************
  // Configuration bits
  // ***********************************************
  always_comb begin
    global_busy_d = global_busy_q;
    freeze_pointer_on_fail_d = freeze_pointer_on_fail_q;
    buf_mode_d = buf_mode_q;
    // Soft reset leaves configuration alone
    if (wr_cfg) begin
      global_busy_d = wdata[GLOBAL_BUSY_BIT];
      freeze_pointer_on_fail_d = wdata[FREEZE_BIT];
      buf_mode_d = buf_mode_t'(wdata[BUF_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      global_busy_q <= 1'b0;
      freeze_pointer_on_fail_q <= 1'b0;
      buf_mode_q <= MODE_PINGPONG;
    end else begin
      global_busy_q <= global_busy_d;
      freeze_pointer_on_fail_q <= freeze_pointer_on_fail_d;
      buf_mode_q <= buf_mode_d;
    end
  end

  // ***********************************************
  // Message tracking
  // ***********************************************
  always_comb begin
    state_d = state_q;
    msg_busy_d = msg_busy_q;
    case (state_q)
      ST_IDLE: begin
        // Busy is latched once so a mid-message write cannot split a reply
        if (msg_start.valid) begin
          state_d = ST_MSG;
          msg_busy_d = busy_now; // [R01] [R03]
        end
      end
      ST_MSG: begin
        if (msg_end.done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (clr) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      msg_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      msg_busy_q <= msg_busy_d;
    end
  end

  // ***********************************************
  // Accessed flag
  // ***********************************************
  always_comb begin
    descriptor_accessed_flag_d = descriptor_accessed_flag_q;
    if (rd_ctrl) begin
      descriptor_accessed_flag_d = 1'b0; // [R05]
    end
    // Completion beats a same-cycle read clear, so no event is lost
    if (msg_done) begin
      descriptor_accessed_flag_d = 1'b1; // [R04] [R06]
    end
    if (clr) begin
      descriptor_accessed_flag_d = 1'b0; // [R05]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      descriptor_accessed_flag_q <= 1'b0; // [R05]
    end else begin
      descriptor_accessed_flag_q <= descriptor_accessed_flag_d;
    end
  end

  // ***********************************************
  // Buffer pointer
  // ***********************************************
  assign ptr_advance = msg_done && pp_active && !msg_busy_q && !msg_end.error
    && !(msg_end.illegal && freeze_pointer_on_fail_q); // [R08] [R02] [R12]

  always_comb begin
    next_buffer_select_d = next_buffer_select_q;
    if (ptr_advance) begin
      next_buffer_select_d = !next_buffer_select_q; // [R08]
    end
    if (clr) begin
      next_buffer_select_d = 1'b0; // [R10]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      next_buffer_select_q <= 1'b0; // [R10]
    end else begin
      next_buffer_select_q <= next_buffer_select_d;
    end
  end

  // ***********************************************
  // Read data
  // ***********************************************
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_ctrl) begin
      rdata_d = ctrl_word;
    end else if (rd_cfg) begin
      rdata_d[GLOBAL_BUSY_BIT] = global_busy_q;
      rdata_d[FREEZE_BIT] = freeze_pointer_on_fail_q;
      rdata_d[BUF_MODE_LSB +: 2] = buf_mode_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign busy_status = (state_q == ST_MSG) && msg_busy_q; // [R01]
  assign send_data = (state_q == ST_MSG) && !msg_busy_q; // [R02]
  // Without the acknowledge the pointer still names the buffer, it just stops toggling
  assign use_buffer_b = pingpong_enable_flag_q && (buf_mode_q == MODE_PINGPONG)
    && next_buffer_select_q; // [R07] [R11] [R12]

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_start;
    (state_q == ST_IDLE) && msg_start.valid && busy_now && !clr;
  endsequence

  sequence s_msg_done;
    msg_done && !clr;
  endsequence

  a_busy_reply: assert property (s_busy_start |=> busy_status && !send_data) // [R01]
    else $error("busy not reported");
  a_busy_keeps_ptr: assert property (busy_status && msg_end.done && !clr |=>
    $stable(next_buffer_select_q)) // [R02]
    else $error("pointer moved on busy message");
  a_sa_busy_alone: assert property (s_busy_start ##0 !global_busy_q |=> busy_status) // [R03]
    else $error("per-subaddress busy ignored");
  a_busy_no_data: assert property (busy_status |-> !send_data) // [R02]
    else $error("data enabled on busy message");
  a_ptr_ack_low: assert property (s_msg_done ##0 !pingpong_ack_flag
    |=> $stable(next_buffer_select_q)) // [R12]
    else $error("pointer toggled without acknowledge");
  a_sel_mode: assert property (buf_mode_q != MODE_PINGPONG |-> !use_buffer_b) // [R11]
    else $error("pointer used outside ping-pong");
  a_sel_follow: assert property (pingpong_enable_flag_q && buf_mode_q == MODE_PINGPONG
    |-> use_buffer_b == next_buffer_select_q) // [R07]
    else $error("buffer select does not follow pointer");
  a_msg_close: assert property (s_msg_done |=> !busy_status && !send_data) // [R04]
    else $error("message did not close");
  a_accessed_hold: assert property (!msg_done && !rd_ctrl && !clr
    |=> $stable(descriptor_accessed_flag_q)) // [R04]
    else $error("accessed flag moved without event");
  a_fb_write: assert property (wr_ctrl |=>
    force_busy_flag_q == $past(wdata[FORCE_BUSY_BIT])) // [R13]
    else $error("force busy write lost");
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not zero");
  a_rd_accessed: assert property (rd_ctrl |=>
    rdata[ACCESSED_BIT] == $past(descriptor_accessed_flag_q)) // [R05]
    else $error("read data lost accessed flag");
  a_state_onehot: assert property ($onehot(state_q))
    else $error("tracking state not one-hot");
  a_accessed_set: assert property ((state_q == ST_MSG) && msg_end.done && !clr |=>
    descriptor_accessed_flag_q) // [R04]
    else $error("accessed flag not set");
  a_accessed_rdclr: assert property (rd && addr == CTRL_ADDR && !(state_q == ST_MSG
    && msg_end.done) |=> !descriptor_accessed_flag_q) // [R05]
    else $error("accessed flag not cleared by read");
  a_ptr_softrst: assert property (clr |=> !next_buffer_select_q && !descriptor_accessed_flag_q) // [R10]
    else $error("soft reset did not clear");
  a_ptr_toggle: assert property ((state_q == ST_MSG) && msg_end.done && pp_active
    && !msg_busy_q && !msg_end.error && !msg_end.illegal && !clr
    |=> next_buffer_select_q != $past(next_buffer_select_q)) // [R08]
    else $error("pointer did not toggle");
  a_ptr_hold: assert property (!pp_active && !clr |=> $stable(next_buffer_select_q)) // [R11]
    else $error("pointer moved outside ping-pong");
  a_busy_hold: assert property (!(wr && addr == CTRL_ADDR) |=> $stable(force_busy_flag_q)) // [R13]
    else $error("force busy changed without write");

endmodule

//--- verification/bc_model.sv
`timescale 1ns/100ps
module bc_model
  import txsa_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command traffic
  output txsa_pkg::msg_start_t msg_start,
  output txsa_pkg::msg_end_t msg_end
);
  initial begin
    msg_start = '0;
    msg_end = '0;
  end
  // Entered just after a rising edge; gap sets how slowly the bus answers
  task automatic send(input logic err, input logic ill, input int gap);
    msg_start <= 1'b1;
    @(posedge mclk);
    msg_start <= 1'b0;
    repeat (gap) @(posedge mclk);
    msg_end <= '{1'b1, err, ill};
    @(posedge mclk);
    msg_end <= '0;
  endtask
endmodule

//--- verification/rt_tx_subaddr_ctrl_bits_test.sv
`timescale 1ns/100ps
module rt_tx_subaddr_ctrl_bits_test;
  import txsa_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, soft_reset_cmd = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic pingpong_ack_flag = 1'b0, ptr = 1'b0;
  logic [15:0] rdata;
  logic busy_status, send_data, use_buffer_b;
  msg_start_t msg_start;
  msg_end_t msg_end;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #5 mclk = ~mclk;
  bc_model bc (.mclk(mclk), .msg_start(msg_start), .msg_end(msg_end));
  rt_tx_subaddr_ctrl_bits dut (.mclk(mclk), .rst_n(rst_n), .soft_reset_cmd(soft_reset_cmd),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .msg_start(msg_start),
    .msg_end(msg_end), .pingpong_ack_flag(pingpong_ack_flag), .busy_status(busy_status),
    .send_data(send_data), .use_buffer_b(use_buffer_b));
  // ***********************************************
  // Helpers
  // ***********************************************
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  function automatic logic [15:0] cw(input logic fb, input logic acc);
    cw = 16'h0004;
    cw[12] = fb;
    cw[11] = acc;
    cw[10] = ptr;
    cw[8] = pingpong_ack_flag;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check(rdata, exp);
    @(posedge mclk);
  endtask
  // Busy and data enables are looked at in the cycle after the start pulse
  task automatic msg(input logic e, input logic il, input logic bz, input logic tg);
    fork
      bc.send(e, il, 2);
      begin
        repeat (2) @(negedge mclk);
        check(busy_status, bz);
        check(send_data, !bz);
      end
    join
    ptr = ptr ^ tg;
    @(negedge mclk);
    check(use_buffer_b, ptr);
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(CTRL_ADDR, 16'h0000);
    rd_chk(CFG_ADDR, 16'h0000);
    wr_reg(4'h7, 16'hffff);
    rd_chk(4'h7, 16'h0000);
    pingpong_ack_flag <= 1'b1;
    wr_reg(CTRL_ADDR, 16'h0d04);
    rd_chk(CTRL_ADDR, cw(1'b0, 1'b0));
    msg(1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(CTRL_ADDR, cw(1'b0, 1'b1));
    rd_chk(CTRL_ADDR, cw(1'b0, 1'b0));
    msg(1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(CTRL_ADDR, cw(1'b0, 1'b1));
    msg(1'b0, 1'b1, 1'b0, 1'b1);
    wr_reg(CFG_ADDR, 16'h0002);
    msg(1'b0, 1'b1, 1'b0, 1'b0);
    wr_reg(CTRL_ADDR, 16'h1004);
    msg(1'b0, 1'b0, 1'b1, 1'b0);
    rd_chk(CTRL_ADDR, cw(1'b1, 1'b1));
    wr_reg(CTRL_ADDR, 16'h0004);
    wr_reg(CFG_ADDR, 16'h0003);
    msg(1'b0, 1'b0, 1'b1, 1'b0);
    wr_reg(CFG_ADDR, 16'h0000);
    msg(1'b0, 1'b0, 1'b0, 1'b1);
    pingpong_ack_flag <= 1'b0;
    msg(1'b0, 1'b0, 1'b0, 1'b0);
    pingpong_ack_flag <= 1'b1;
    wr_reg(CFG_ADDR, 16'h0004);
    check(use_buffer_b, 16'h0000);
    wr_reg(CFG_ADDR, 16'h0000);
    msg(1'b0, 1'b0, 1'b0, 1'b1);
    msg(1'b0, 1'b0, 1'b0, 1'b1);
    wr_reg(CTRL_ADDR, 16'h1004);
    soft_reset_cmd <= 1'b1;
    @(posedge mclk);
    soft_reset_cmd <= 1'b0;
    ptr = 1'b0;
    rd_chk(CTRL_ADDR, cw(1'b1, 1'b0));
    end_sim();
  end
endmodule
